/* File: status_monitor_pkg.sv */
package status_monitor_pkg;
    localparam int digit_count = 8;
    // digit positions (index 0 is digit 1, the rightmost)
    localparam int in_safety_pos = 0;
    localparam int in_fwd_ot_pos = 1;
    localparam int in_rev_ot_pos = 2;
    localparam int in_decel_pos = 3;
    localparam int in_latch_pos = 4;
    localparam int in_reserved_pos = 7;
    localparam int out_fault_pos = 0;
    localparam int out_brake_pos = 1;
    localparam int out_gen_pos = 2;
    localparam int safe_one_pos = 0;
    localparam int safe_two_pos = 1;
    // segment levels per digit: upper or lower bar
    localparam logic seg_upper = 1'b1;
    localparam logic seg_lower = 1'b0;
    localparam logic [7:0] reset_upper = 8'h00;
    localparam logic [7:0] reset_lower = 8'hff;
    typedef enum logic [2:0] {
        item_input = 3'b001,
        item_output = 3'b010,
        item_safety = 3'b100
    } item_t;
endpackage

/* File: io_status_monitor_display.sv */
// How it works
// - input/output groups: OFF lights upper bar, ON lower; undefined digits lower.
// - input item digits: safety, fwd/rev overtravel, decel, three latches, reserved.
// - output item digits: fault, brake, two general outputs, four reserved.
// - safety group reversed: ON upper bar, OFF lower; undefined digits lower.
// - safety item digit 1 block input one, digit 2 block input two.
// - input contact open is OFF, shorted is ON.
// - output is ON while its transistor conducts.
// - block input one OFF raises safe blocking and shows OFF.
module io_status_monitor_display
    import status_monitor_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,

    // item selection from panel navigation
    input wire item_t item_select,

    // general inputs, high when the contact is shorted
    input wire logic safety_input_zero,
    input wire logic forward_overtravel,
    input wire logic reverse_overtravel,
    input wire logic homing_decel_input,
    input wire logic external_latch_one,
    input wire logic external_latch_two,
    input wire logic external_latch_three,

    // transistor outputs, high when conducting
    input wire logic fault_output,
    input wire logic brake_control_output,
    input wire logic general_output_two,
    input wire logic general_output_three,

    // safety inputs, high when the contact is shorted
    input wire logic safe_block_input_one,
    input wire logic safe_block_input_two,

    // display: one bit set per lit bar
    output logic [7:0] upper_segment,
    output logic [7:0] lower_segment,

    // on state of each digit, per group
    output logic [7:0] input_status_item,
    output logic [7:0] output_status_item,
    output logic [7:0] safety_status_item,

    // safe blocking and refresh pulse
    output logic hardware_safe_blocking,
    output logic display_update
);
    // on states per group, bit i is digit i+1
    logic [7:0] in_on;
    logic [7:0] out_on;
    logic [7:0] safe_on;
    logic [7:0] next_in_on;
    logic [7:0] next_out_on;
    logic [7:0] next_safe_on;

    // bar pattern of the selected item
    logic [7:0] next_upper;
    logic [7:0] next_lower;

    // safe blocking and refresh pulse
    logic next_blocking;
    logic next_update;

    // defined digits of each group and of the selected item
    logic [7:0] in_mask;
    logic [7:0] out_mask;
    logic [7:0] safe_mask;
    logic [7:0] sel_on;
    logic [7:0] sel_mask;
    logic sel_reverse;

    // input group: a shorted contact reads as ON
    always_comb begin
        next_in_on = 8'h00;
        next_in_on[in_safety_pos] = safety_input_zero;
        next_in_on[in_fwd_ot_pos] = forward_overtravel;
        next_in_on[in_rev_ot_pos] = reverse_overtravel;
        next_in_on[in_decel_pos] = homing_decel_input;
        next_in_on[in_latch_pos] = external_latch_one;
        next_in_on[in_latch_pos + 1] = external_latch_two;
        next_in_on[in_latch_pos + 2] = external_latch_three;
    end

    // output group: a conducting transistor reads as ON
    always_comb begin
        next_out_on = 8'h00;
        next_out_on[out_fault_pos] = fault_output;
        next_out_on[out_brake_pos] = brake_control_output;
        next_out_on[out_gen_pos] = general_output_two;
        next_out_on[out_gen_pos + 1] = general_output_three;
    end

    // safety group; blocking follows block input one alone, the second
    // input is only shown on the panel
    always_comb begin
        next_safe_on = 8'h00;
        next_safe_on[safe_one_pos] = safe_block_input_one;
        next_safe_on[safe_two_pos] = safe_block_input_two;
        next_blocking = ~safe_block_input_one;
    end

    // defined digit masks per group
    // built from the digit positions so a moved signal cannot leave a
    // stale mask behind
    always_comb begin
        in_mask = 8'h00;
        in_mask[in_safety_pos] = 1'b1;
        in_mask[in_fwd_ot_pos] = 1'b1;
        in_mask[in_rev_ot_pos] = 1'b1;
        in_mask[in_decel_pos] = 1'b1;
        in_mask[in_latch_pos] = 1'b1;
        in_mask[in_latch_pos + 1] = 1'b1;
        in_mask[in_latch_pos + 2] = 1'b1;
        in_mask[in_reserved_pos] = 1'b0;
        out_mask = 8'h00;
        out_mask[out_fault_pos] = 1'b1;
        out_mask[out_brake_pos] = 1'b1;
        out_mask[out_gen_pos] = 1'b1;
        out_mask[out_gen_pos + 1] = 1'b1;
        safe_mask = 8'h00;
        safe_mask[safe_one_pos] = 1'b1;
        safe_mask[safe_two_pos] = 1'b1;
    end

    always_comb begin
        case (item_select)
            item_input: begin
                sel_on = next_in_on;
                sel_mask = in_mask;
                sel_reverse = 1'b0;
            end
            item_output: begin
                sel_on = next_out_on;
                sel_mask = out_mask;
                sel_reverse = 1'b0;
            end
            item_safety: begin
                sel_on = next_safe_on;
                sel_mask = safe_mask;
                sel_reverse = 1'b1;
            end
            // codes off the one-hot set fall back to the input item
            default: begin
                sel_on = next_in_on;
                sel_mask = in_mask;
                sel_reverse = 1'b0;
            end
        endcase
    end

    genvar d;
    generate
        for (d = 0; d < digit_count; d++) begin : g_digit
            logic up;
            // undefined digits always sit on the lower bar
            always_comb begin
                if (!sel_mask[d]) begin
                    up = seg_lower;
                end else if (sel_reverse) begin
                    up = sel_on[d] ? seg_upper : seg_lower;
                end else begin
                    up = sel_on[d] ? seg_lower : seg_upper;
                end
            end
            // exactly one bar of each digit is lit at any time
            assign next_upper[d] = up;
            assign next_lower[d] = ~up;
        end
    endgenerate

    // pulse when any shown bar moves; it rises in the same cycle as the new bars
    assign next_update = (next_upper != upper_segment);

    // status words, one flop per digit
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            in_on <= 8'h00;
            out_on <= 8'h00;
            safe_on <= 8'h00;
        end else begin
            in_on <= next_in_on;
            out_on <= next_out_on;
            safe_on <= next_safe_on;
        end
    end

    // both bar words are flops so the panel never sees a glitch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            upper_segment <= reset_upper;
            lower_segment <= reset_lower;
        end else begin
            upper_segment <= next_upper;
            lower_segment <= next_lower;
        end
    end

    // blocking resets active: the drive stays safe until inputs are read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            hardware_safe_blocking <= 1'b1;
        end else begin
            hardware_safe_blocking <= next_blocking;
        end
    end

    // refresh pulse for the panel driver, one cycle per change
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            display_update <= 1'b0;
        end else begin
            display_update <= next_update;
        end
    end

    assign input_status_item = in_on;
    assign output_status_item = out_on;
    assign safety_status_item = safe_on;
endmodule

/* File: status_check_monitor.sv */
module status_check_monitor
    import status_monitor_pkg::*;
(
    input wire logic sys_clk, rst, safe_block_input_one, safe_block_input_two,
    input wire logic hardware_safe_blocking, display_update,
    input wire item_t item_select,
    input wire logic [7:0] upper_segment, lower_segment, input_status_item,
    input wire logic [7:0] output_status_item, safety_status_item
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_bars_complement: assert property (
        lower_segment == ~upper_segment) else $error("bars");
    a_input_bars: assert property (
        !$past(rst) && !($past(item_select) inside {item_output, item_safety})
        |-> upper_segment == (~input_status_item & 8'h7f)) else $error("in");
    a_output_bars: assert property (
        !$past(rst) && $past(item_select) == item_output
        |-> upper_segment == (~output_status_item & 8'h0f)) else $error("out");
    a_safety_bars: assert property (
        !$past(rst) && $past(item_select) == item_safety
        |-> upper_segment == safety_status_item) else $error("safe");
    a_block_follows: assert property (
        !$past(rst) |-> hardware_safe_blocking == !$past(safe_block_input_one))
        else $error("block");
    a_safety_item: assert property (
        !$past(rst) |-> safety_status_item == {6'h0,
        $past(safe_block_input_two), $past(safe_block_input_one)})
        else $error("safe item");
    a_reserved_clear: assert property (
        input_status_item[7] == 1'b0 && output_status_item[7:4] == 4'h0)
        else $error("reserved");
    a_refresh_pulse: assert property (
        !$past(rst) && !$past(rst, 2) |->
        display_update == (upper_segment != $past(upper_segment)))
        else $error("update");
    c_blocked: cover property (item_select == item_safety && !safe_block_input_one);
    c_output: cover property (item_select == item_output);
    c_refresh: cover property (display_update);
endmodule
bind io_status_monitor_display status_check_monitor u_mon (.*);

/* File: panel_reader.sv */
module panel_reader (
    input wire logic [7:0] upper_segment,
    output logic [7:0] seen_low
);
    timeunit 1ns;
    timeprecision 1ps;
    // an operator only tells the two bars apart
    assign seen_low = ~upper_segment;
endmodule

/* File: io_status_monitor_display_test.sv */
module io_status_monitor_display_test;
    import status_monitor_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 0, rst = 1;
    item_t item_select = item_input;
    logic safety_input_zero, forward_overtravel, reverse_overtravel;
    logic homing_decel_input, external_latch_one, external_latch_two;
    logic external_latch_three, fault_output, brake_control_output;
    logic general_output_two, general_output_three;
    logic safe_block_input_one, safe_block_input_two;
    logic [7:0] upper_segment, lower_segment, input_status_item, seen_low;
    logic [7:0] output_status_item, safety_status_item, up, prev;
    logic hardware_safe_blocking, display_update;
    logic [12:0] v = 13'h0;
    logic [49:0] q[$];
    logic [49:0] seen, want;
    int bad_count = 0, n_checks = 0;
    always #5 sys_clk = ~sys_clk;
    panel_reader u_panel (.upper_segment(upper_segment), .seen_low(seen_low));
    io_status_monitor_display u_dut (.*);
    assign {safe_block_input_two, safe_block_input_one, general_output_three,
        general_output_two, brake_control_output, fault_output,
        external_latch_three, external_latch_two, external_latch_one,
        homing_decel_input, reverse_overtravel, forward_overtravel,
        safety_input_zero} = v;
    task results;
        if (bad_count == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task check(input logic [49:0] got, input logic [49:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    initial begin
        static item_t codes[4] = '{item_input, item_output, item_safety,
            item_t'(3'h0)};
        void'($urandom(32'h6116));
        repeat (2) @(posedge sys_clk);
        #1 rst = 0;
        for (int i = 0; i < 400; i++) begin
            v = 13'($urandom);
            item_select = codes[2'($urandom)];
            up = item_select == item_output ? {4'h0, ~v[10:7]} :
                item_select == item_safety ? {6'h0, v[12:11]} : {1'b0, ~v[6:0]};
            if (i > 0) q.push_back({up != prev, ~v[11], 6'h0, v[12:11],
                4'h0, v[10:7], 1'b0, v[6:0], up, ~up, ~up});
            prev = up;
            @(posedge sys_clk) #1;
        end
        results();
    end
    always @(posedge sys_clk) begin
        #2;
        seen = {display_update, hardware_safe_blocking, safety_status_item,
            output_status_item, input_status_item, upper_segment,
            lower_segment, seen_low};
        if (q.size() > 1) begin
            want = q.pop_front();
            check(seen[49:48], want[49:48]);
            check(seen[47:24], want[47:24]);
            check(seen[23:0], want[23:0]);
        end
    end
    initial begin
        #6000;
        bad_count++;
        results();
    end
endmodule
